// [amio_ports.v]
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "amio_defs.vh"
module amio_ports #(
   parameter WIDTH = 8
) (
   input  wire             clk_in,
   input  wire             nrst_in,
   input  wire             hsel_in,
   input  wire [31:0]      haddr_in,
   input  wire [1:0]       htrans_in,
   input  wire             hwrite_in,
   input  wire [2:0]       hsize_in,
   input  wire [31:0]      hwdata_in,
   input  wire             hready_in,
   output wire [31:0]      hrdata_out,
   output wire             hreadyout_out,
   output wire             hresp_out,
   input  wire [1:0]       op_mode_in,
   input  wire             expansion_enable_in,
   input  wire             hw_standby_in,
   input  wire [15:0]      ext_addr_in,
   input  wire [WIDTH-1:0] p1_pin_in,
   output wire [WIDTH-1:0] p1_pin_out,
   output wire [WIDTH-1:0] p1_pin_oe_out,
   output wire [WIDTH-1:0] p1_pullup_out,
   input  wire [WIDTH-1:0] p2_pin_in,
   output wire [WIDTH-1:0] p2_pin_out,
   output wire [WIDTH-1:0] p2_pin_oe_out
);

   reg  [WIDTH-1:0] port_one_direction_r;
   reg  [WIDTH-1:0] port_one_output_data_r;
   reg  [WIDTH-1:0] port_one_pullup_control_r;
   reg  [WIDTH-1:0] port_two_direction_r;
   reg  [WIDTH-1:0] port_two_output_data_r;
   reg              io_strobe_select_r;
   reg  [WIDTH-1:0] p1_meta_r;
   reg  [WIDTH-1:0] p1_sync_r;
   reg  [WIDTH-1:0] p2_meta_r;
   reg  [WIDTH-1:0] p2_sync_r;
   reg              wr_pend_r;
   reg  [11:0]      wr_addr_r;
   reg  [31:0]      rdata_r;
   wire             mode_one;
   wire             expanded;
   wire             accept;
   wire [11:0]      offs;
   wire [WIDTH-1:0] p1_addr_sel;
   wire [WIDTH-1:0] p2_addr_sel;
   wire [WIDTH-1:0] p1_rd;
   wire [WIDTH-1:0] p2_rd;
   reg  [31:0]      rdata_nxt;

   // mixes stored output data with pin level per direction bit
   function [WIDTH-1:0] port_read;
      input [WIDTH-1:0] dir;
      input [WIDTH-1:0] dat;
      input [WIDTH-1:0] pin;
      begin
         port_read = (dir & dat) | (~dir & pin);
      end
   endfunction

   // mode and expansion are straps held steady by the system, so no sync
   assign mode_one = (op_mode_in == `AMIO_MODE_ONE); // see [RQ16]
   assign expanded = ~mode_one & expansion_enable_in; // see [RQ16]

   // pins cross in from outside; two flops before any reader
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         p1_meta_r <= `AMIO_RST_BYTE;
         p1_sync_r <= `AMIO_RST_BYTE;
         p2_meta_r <= `AMIO_RST_BYTE;
         p2_sync_r <= `AMIO_RST_BYTE;
      end else begin
         p1_meta_r <= p1_pin_in;
         p1_sync_r <= p1_meta_r;
         p2_meta_r <= p2_pin_in;
         p2_sync_r <= p2_meta_r;
      end
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
         // port one: address in mode 1 or expanded with direction set
         assign p1_addr_sel[i] = mode_one | (expanded & port_one_direction_r[i]); // see [RQ8] [RQ9]
         assign p1_pin_out[i]  = p1_addr_sel[i] ? ext_addr_in[i]
                                                : port_one_output_data_r[i]; // see [RQ10]
         assign p1_pin_oe_out[i] = mode_one | port_one_direction_r[i]; // see [RQ9] [RQ10]
         // pull-up only for inputs, never in mode 1 or hardware standby
         assign p1_pullup_out[i] = ~mode_one & ~hw_standby_in & ~port_one_direction_r[i]
                                   & port_one_pullup_control_r[i]; // see [RQ5] [RQ6] [RQ7]
         // upper nibble leaves the address bus in expanded mode when strobe select is set
         if (i >= 4) begin : g_hi
            assign p2_addr_sel[i] = mode_one | (expanded & port_two_direction_r[i]
                                    & ~io_strobe_select_r); // see [RQ11] [RQ13]
         end else begin : g_lo
            assign p2_addr_sel[i] = mode_one | (expanded & port_two_direction_r[i]); // see [RQ12]
         end
         assign p2_pin_out[i] = p2_addr_sel[i] ? ext_addr_in[WIDTH+i]
                                               : port_two_output_data_r[i]; // see [RQ15]
         assign p2_pin_oe_out[i] = mode_one | port_two_direction_r[i]; // see [RQ11] [RQ15]
      end
   endgenerate

   assign p1_rd = port_read(port_one_direction_r, port_one_output_data_r, p1_sync_r); // see [RQ3]
   assign p2_rd = port_read(port_two_direction_r, port_two_output_data_r, p2_sync_r); // see [RQ4]

   // ahb-lite slave: zero wait states, always okay
   assign offs          = haddr_in[11:0];
   assign accept        = hsel_in & hready_in & (htrans_in == `AMIO_HTRANS_NONSEQ);
   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;
   assign hrdata_out    = rdata_r;

   // direction registers are write-only and read back as zero
   always @* begin
      rdata_nxt = 32'h0000_0000;
      case (offs)
         `AMIO_OFS_P1_DATA: rdata_nxt[WIDTH-1:0] = p1_rd;
         `AMIO_OFS_P1_PULL: rdata_nxt[WIDTH-1:0] = port_one_pullup_control_r;
         `AMIO_OFS_P2_DATA: rdata_nxt[WIDTH-1:0] = p2_rd;
         `AMIO_OFS_CONFIG:  rdata_nxt[`AMIO_CFG_STROBE_SEL_BIT] = io_strobe_select_r; // see [RQ13]
         default:           rdata_nxt = 32'h0000_0000;
      endcase
   end

   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 12'h000;
         rdata_r   <= 32'h0000_0000;
      end else begin
         wr_pend_r <= accept & hwrite_in;
         if (accept) begin
            wr_addr_r <= offs;
         end
         if (accept & ~hwrite_in) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   // write data arrives in the data phase, one cycle after the address
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         port_one_direction_r      <= `AMIO_RST_BYTE; // see [RQ1]
         port_one_output_data_r    <= `AMIO_RST_BYTE; // see [RQ2]
         port_one_pullup_control_r <= `AMIO_RST_BYTE;
         port_two_direction_r      <= `AMIO_RST_BYTE;
         port_two_output_data_r    <= `AMIO_RST_BYTE; // see [RQ2]
         io_strobe_select_r        <= 1'b0;
      end else if (wr_pend_r) begin
         case (wr_addr_r)
            `AMIO_OFS_P1_DIR:  port_one_direction_r      <= hwdata_in[WIDTH-1:0]; // see [RQ1]
            `AMIO_OFS_P1_DATA: port_one_output_data_r    <= hwdata_in[WIDTH-1:0]; // see [RQ2]
            `AMIO_OFS_P1_PULL: port_one_pullup_control_r <= hwdata_in[WIDTH-1:0]; // see [RQ5]
            `AMIO_OFS_P2_DIR:  port_two_direction_r      <= hwdata_in[WIDTH-1:0]; // see [RQ15]
            `AMIO_OFS_P2_DATA: port_two_output_data_r    <= hwdata_in[WIDTH-1:0]; // see [RQ2]
            `AMIO_OFS_CONFIG:  io_strobe_select_r        <= hwdata_in[`AMIO_CFG_STROBE_SEL_BIT]; // see [RQ13]
            default:           io_strobe_select_r        <= io_strobe_select_r;
         endcase
      end
   end

endmodule // amio_ports

// [amio_defs.vh]
// Contract
// [RQ1] port one direction register is write-only, per bit, reset zero
// [RQ2] both ports eight bits; output data registers hold general output values
// [RQ3] port one read: data register where direction one, pin level where zero
// [RQ4] port two read: stored data where direction one, pin state where zero
// [RQ5] software enables each port one pull-up by its pull-up control bit
// [RQ6] mode 1 keeps every port one pull-up off in every state
// [RQ7] modes 2/3: pull-up on only for input pin, direction 0, pull-up bit 1
// [RQ8] mode 1: all port one pins drive address bits 7 to 0
// [RQ9] modes 2/3 expanded: port one drives address if direction 1, else input
// [RQ10] modes 2/3 single-chip: port one general output if direction 1, else input
// [RQ11] mode 1: all port two pins drive the upper address byte
// [RQ12] modes 2/3 expanded: port two drives address if direction 1, else input
// [RQ13] expanded with strobe select 1: upper four port two pins become outputs; the code enables them only where the direction bit is 1
// [RQ14] software keeps peripheral outputs off port two while it carries address
// [RQ15] modes 2/3 single-chip: port two general output if direction 1, else input
// [RQ16] mode and expansion enable are static inputs; pins follow combinationally
`ifndef AMIO_DEFS_VH
`define AMIO_DEFS_VH
`define AMIO_OFS_P1_DIR   12'h000
`define AMIO_OFS_P1_DATA  12'h004
`define AMIO_OFS_P1_PULL  12'h008
`define AMIO_OFS_P2_DIR   12'h00C
`define AMIO_OFS_P2_DATA  12'h010
`define AMIO_OFS_CONFIG   12'h014
`define AMIO_RST_BYTE     8'h00
`define AMIO_MODE_ONE     2'h1
`define AMIO_CFG_STROBE_SEL_BIT 0
`define AMIO_HTRANS_NONSEQ 2'h2
`endif

// [amio_chk_assertions.sv]
`timescale 1ns/1ps
module amio_chk #(
   parameter WIDTH = 8
) (
   input logic             clk_in,
   input logic             nrst_in,
   input logic [1:0]       op_mode_in,
   input logic             expansion_enable_in,
   input logic             hw_standby_in,
   input logic [15:0]      ext_addr_in,
   input logic [WIDTH-1:0] p1_pin_out,
   input logic [WIDTH-1:0] p1_pin_oe_out,
   input logic [WIDTH-1:0] p1_pullup_out,
   input logic [WIDTH-1:0] p2_pin_out,
   input logic [WIDTH-1:0] p2_pin_oe_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   wire m1 = (op_mode_in == 2'h1);
   wire xp = !m1 && expansion_enable_in;
   p1_oe_a: assert property (m1 |-> &p1_pin_oe_out) else $error("p1 not driven");
   p1_addr_a: assert property (m1 |-> p1_pin_out == ext_addr_in[7:0]) else $error("p1 addr");
   p2_addr_a: assert property (m1 |-> &p2_pin_oe_out && p2_pin_out == ext_addr_in[15:8])
      else $error("p2 addr");
   pull_mode1_a: assert property (m1 |-> p1_pullup_out == 8'h00) else $error("pull in mode 1");
   pull_stby_a: assert property ($rose(hw_standby_in) |-> !p1_pullup_out) else $error("pull stby");
   pull_input_a: assert property ((p1_pullup_out & p1_pin_oe_out) == 8'h00) else $error("pull out");
   p1_exp_a: assert property (xp |-> ((p1_pin_out ^ ext_addr_in[7:0]) & p1_pin_oe_out) == 8'h00)
      else $error("p1 exp");
   p2_exp_a: assert property (xp |-> ((p2_pin_out[3:0] ^ ext_addr_in[11:8]) & p2_pin_oe_out[3:0]) == 4'h0)
      else $error("p2 exp");
endmodule // amio_chk

// [amio_pins.sv]
`timescale 1ns/1ps
module amio_pins (
   input  logic [7:0]  p1_pin_out,
   input  logic [7:0]  p1_pin_oe_out,
   input  logic [7:0]  p1_pullup_out,
   input  logic [7:0]  p2_pin_out,
   input  logic [7:0]  p2_pin_oe_out,
   input  logic [15:0] ext_v,
   input  logic [15:0] ext_en,
   output logic [7:0]  p1_pin_in,
   output logic [7:0]  p2_pin_in
);
   wire [15:0] oe = {p2_pin_oe_out, p1_pin_oe_out};
   // undriven pins without pull-up read low; tests never rely on them otherwise
   assign {p2_pin_in, p1_pin_in} = (oe & {p2_pin_out, p1_pin_out}) | (~oe & ext_en & ext_v)
      | (~oe & ~ext_en & {8'h00, p1_pullup_out});
endmodule // amio_pins

// [tb_top.sv]
`timescale 1ns/1ps
`define CK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
   logic        clk_in, nrst_in, hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out;
   logic        hw_standby_in, expansion_enable_in;
   logic [31:0] haddr_in, hwdata_in, hrdata_out;
   logic [1:0]  htrans_in, op_mode_in;
   logic [2:0]  hsize_in;
   logic [15:0] ext_addr_in, ext_v, ext_en;
   logic [7:0]  p1_pin_in, p1_pin_out, p1_pin_oe_out, p1_pullup_out;
   logic [7:0]  p2_pin_in, p2_pin_out, p2_pin_oe_out;
   int          checks, miscompares;
   assign hready_in = hreadyout_out;
   amio_ports i_dut (.clk_in, .nrst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in,
      .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .op_mode_in,
      .expansion_enable_in, .hw_standby_in, .ext_addr_in, .p1_pin_in, .p1_pin_out,
      .p1_pin_oe_out, .p1_pullup_out, .p2_pin_in, .p2_pin_out, .p2_pin_oe_out);
   amio_pins i_pins (.p1_pin_out, .p1_pin_oe_out, .p1_pullup_out, .p2_pin_out, .p2_pin_oe_out,
      .ext_v, .ext_en, .p1_pin_in, .p2_pin_in);
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   task give_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task wt;
      int n;
      n = 0;
      @(posedge clk_in);
      while (hreadyout_out !== 1'b1) begin
         n++;
         if (n > 99) begin miscompares++; give_verdict; end
         @(posedge clk_in);
      end
   endtask
   task xf(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
      haddr_in <= {20'h00000, a}; hwrite_in <= w; htrans_in <= 2'h2;
      wt;
      htrans_in <= 2'h0; hwdata_in <= {24'h000000, d};
      wt;
      if (!w) `CK(hrdata_out, {24'h000000, e})
   endtask
   // pins pass two sync flops, so settle a few edges before looking
   task st;
      repeat (3) @(posedge clk_in);
   endtask
   initial begin
      nrst_in = 1'b0; hsel_in = 1'b1; hwrite_in = 1'b0; htrans_in = 2'h0; haddr_in = 32'h0;
      hwdata_in = 32'h0; hsize_in = 3'h2; op_mode_in = 2'h2; expansion_enable_in = 1'b0;
      hw_standby_in = 1'b0; ext_addr_in = 16'hBEEF; ext_v = 16'h033C; ext_en = 16'h0FF0;
      checks = 0; miscompares = 0;
      repeat (20) @(posedge clk_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      xf(1'b0, 12'h000, 8'h00, 8'h00);
      `CK(hresp_out, 1'b0)
      xf(1'b0, 12'h004, 8'h00, 8'h30);
      xf(1'b0, 12'h008, 8'h00, 8'h00);
      xf(1'b0, 12'h010, 8'h00, 8'h03);
      xf(1'b1, 12'h000, 8'h0F, 8'h00);
      xf(1'b1, 12'h004, 8'hA5, 8'h00);
      xf(1'b1, 12'h00C, 8'hF0, 8'h00);
      xf(1'b1, 12'h010, 8'h5A, 8'h00);
      xf(1'b1, 12'h018, 8'hFF, 8'h00);
      xf(1'b0, 12'h004, 8'h00, 8'h35);
      xf(1'b0, 12'h010, 8'h00, 8'h53);
      xf(1'b0, 12'h000, 8'h00, 8'h00);
      xf(1'b0, 12'h018, 8'h00, 8'h00);
      `CK({p2_pin_oe_out, p1_pin_oe_out, p1_pin_out & 8'h0F}, 24'hF00F05)
      ext_en <= 16'h0F00;
      xf(1'b1, 12'h008, 8'hFF, 8'h00);
      st;
      `CK(p1_pullup_out, 8'hF0)
      xf(1'b0, 12'h004, 8'h00, 8'hF5);
      hw_standby_in <= 1'b1;
      st;
      `CK(p1_pullup_out, 8'h00)
      hw_standby_in <= 1'b0; expansion_enable_in <= 1'b1;
      st;
      `CK(p1_pin_out & p1_pin_oe_out, 8'h0F)
      `CK({p2_pin_oe_out, p2_pin_out & 8'hF0}, 16'hF0B0)
      xf(1'b1, 12'h014, 8'h01, 8'h00);
      st;
      `CK(p2_pin_out & 8'hF0, 8'h50)
      xf(1'b0, 12'h014, 8'h00, 8'h01);
      op_mode_in <= 2'h1;
      st;
      `CK({p2_pin_oe_out, p1_pin_oe_out, p2_pin_out, p1_pin_out}, 32'hFFFFBEEF)
      `CK(p1_pullup_out, 8'h00)
      ext_addr_in <= 16'h1234;
      st;
      `CK({p2_pin_out, p1_pin_out}, 16'h1234)
      give_verdict;
   end
endmodule // tb_top
bind amio_ports amio_chk #(.WIDTH(WIDTH)) i_chk (.clk_in, .nrst_in, .op_mode_in,
   .expansion_enable_in, .hw_standby_in, .ext_addr_in, .p1_pin_out, .p1_pin_oe_out,
   .p1_pullup_out, .p2_pin_out, .p2_pin_oe_out);
